//--- src/utt_pkg.sv
package utt_pkg;

  localparam int TIMERS = 2;

  // Register page in which both timers live.
  localparam logic [7:0] SFR_PAGE = 8'h10;

  // Control register address of each timer; the other registers follow it.
  localparam logic [7:0] TMR_BASE [0:TIMERS-1] = '{8'h91, 8'hc8};
  localparam logic [7:0] OFF_CTL = 8'h00;
  localparam logic [7:0] OFF_CFG = 8'h01;
  localparam logic [7:0] OFF_CAPL = 8'h02;
  localparam logic [7:0] OFF_CAPH = 8'h03;
  localparam logic [7:0] OFF_CNTL = 8'h04;
  localparam logic [7:0] OFF_CNTH = 8'h05;

  // Only the second timer's control register answers single-bit writes.
  localparam int BIT_TMR = 1;

  // Control register fields.
  localparam int CTL_WRAP = 7;
  localparam int CTL_EXT = 6;
  localparam int CTL_EXT_EDGE_ENABLE = 3;
  localparam int CTL_RUN = 2;
  localparam int CTL_CT = 1;
  localparam int CTL_CPRL = 0;

  // Configuration register fields.
  localparam int CFG_CLK_HI = 4;
  localparam int CFG_CLK_LO = 3;
  localparam int CFG_TOG = 2;
  localparam int CFG_TOE = 1;
  localparam int CFG_DCEN = 0;

  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_MIN = 16'h0000;
  localparam logic [7:0] RDATA_NONE = 8'h00;

  // Timer clock selections and their system clock divisors.
  typedef enum logic [1:0] {
    UTT_CLK_DIV12 = 2'h0,
    UTT_CLK_DIV1 = 2'h1,
    UTT_CLK_DIV2 = 2'h2,
    UTT_CLK_DIV8 = 2'h3
  } utt_clk_sel_t;

  localparam logic [3:0] DIV12 = 4'hc;
  localparam logic [3:0] DIV1 = 4'h1;
  localparam logic [3:0] DIV2 = 4'h2;
  localparam logic [3:0] DIV8 = 4'h8;
  localparam logic [3:0] PRE_ZERO = 4'h0;
  localparam logic [3:0] PRE_ONE = 4'h1;

  // Byte access request on the special-function register port.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } utt_sfr_req_t;

  // Single-bit write request; addr selects register base plus bit number.
  typedef struct packed {
    logic wr;
    logic [7:0] page;
    logic [7:0] addr;
    logic val;
  } utt_bit_req_t;

endpackage : utt_pkg

//--- src/utt_edge_sync.sv
module utt_edge_sync
  import utt_pkg::*;
(
  input wire logic sys_clk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic pin_in, // Raw external control level.
  output logic level, // Synchronised level.
  output logic fall // One-cycle pulse on a high-to-low change.
);

  logic meta_reg, meta_next;
  logic sync_reg, sync_next;
  logic prev_reg, prev_next;

  // Resetting to high makes a pin that is low at release look like a falling edge.
  always_comb begin
    meta_next = pin_in;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  assign level = sync_reg;
  assign fall = prev_reg & ~sync_reg; // R22

endmodule // utt_edge_sync

//--- src/utt_prescaler.sv
module utt_prescaler
  import utt_pkg::*;
(
  input wire logic sys_clk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire utt_clk_sel_t sel, // Timer clock selection.
  output logic tick // One-cycle timer clock pulse.
);

  logic [3:0] cnt_reg, cnt_next;
  logic [3:0] div;

  always_comb begin
    case (sel)
      UTT_CLK_DIV1: div = DIV1;
      UTT_CLK_DIV2: div = DIV2;
      UTT_CLK_DIV8: div = DIV8;
      default: div = DIV12;
    endcase
    // A change of divisor may cut one period short; the count carries on and wraps at once if it has reached the new end.
    if (cnt_reg + PRE_ONE >= div) begin
      cnt_next = PRE_ZERO;
    end else begin
      cnt_next = cnt_reg + PRE_ONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_reg <= PRE_ZERO;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign tick = (cnt_reg + PRE_ONE >= div);

endmodule // utt_prescaler

//--- src/utt_top.sv
// Overview of operation
// (R1) Wrap inverts toggle state, square wave out.
// (R2) Down reload: match capture, load 0xFFFF.
// (R3) Up reload: past 0xFFFF loads capture pair.
// (R4) Software clears mode bits for square wave.
// (R5) Pin driven only while output enable set.
// (R6) Software picks clock and reload for rate.
// (R7) No toggling before run bit set.
// (R8) Toggle bit reads level, write forces it.
// (R9) Wrap flag bit 7 on every wrap.
// (R10) Wrap flag requests interrupt, software clears.
// (R11) Ext flag bit 6 on edge capture/reload.
// (R12) Software writes zero to bits 5:4.
// (R13) Ext enable low ignores control input; its falling edges still count while the count source bit is set.
// (R14) Capture mode edge copies counter to pair.
// (R15) Reload mode edge reloads, sets ext flag.
// (R16) Direction enable: input level picks direction; here only in reload mode with ext enable set, capture counts down.
// (R17) Control registers reset zero, page 0x10.
// (R18) Run bit low stops, high counts.
// (R19) Select bit: 0 reload, 1 capture.
// (R20) Count source bit counts input falling edges.
// (R21) Forced toggle write wins next edge.
// (R22) Control input synchronised, edges detected.
module utt_top
  import utt_pkg::*;
(
  input wire logic sys_clk, // System clock, 25 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire utt_sfr_req_t sfr_req, // Byte register access.
  input wire utt_bit_req_t bit_req, // Single-bit register write.
  output logic [7:0] sfr_rdata, // Read data, one cycle after rd.
  input wire logic ext_control_input_a, // External control input, timer a.
  input wire logic ext_control_input_b, // External control input, timer b.
  output logic toggle_out_pin_a, // Toggle output, timer a.
  output logic toggle_out_oe_a, // Output enable, timer a.
  output logic toggle_out_pin_b, // Toggle output, timer b.
  output logic toggle_out_oe_b, // Output enable, timer b.
  output logic wrap_irq_a, // Wrap flag level, timer a.
  output logic wrap_irq_b // Wrap flag level, timer b.
);

  logic [7:0] ctl_reg [0:TIMERS-1];
  logic [7:0] ctl_next [0:TIMERS-1];
  logic [7:0] cfg_reg [0:TIMERS-1];
  logic [7:0] cfg_next [0:TIMERS-1];
  logic [15:0] cap_reg [0:TIMERS-1];
  logic [15:0] cap_next [0:TIMERS-1];
  logic [15:0] cnt_reg [0:TIMERS-1];
  logic [15:0] cnt_next [0:TIMERS-1];
  logic [7:0] rdata_reg, rdata_next;
  logic [TIMERS-1:0] ex_level, ex_fall, pre_tick, tick, down, ext_trig, wrap;
  logic [TIMERS-1:0] wr_ctl, wr_cfg, wr_capl, wr_caph, wr_cntl, wr_cnth, wr_bit;
  logic [TIMERS-1:0] ext_pins;
  logic page_ok, bit_page_ok;

  assign ext_pins = {ext_control_input_b, ext_control_input_a};
  assign page_ok = (sfr_req.page == SFR_PAGE); // R17
  assign bit_page_ok = (bit_req.page == SFR_PAGE);

  for (genvar g = 0; g < TIMERS; g++) begin : g_tmr
    utt_edge_sync u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .pin_in(ext_pins[g]),
      .level(ex_level[g]),
      .fall(ex_fall[g])
    );
    utt_prescaler u_pre (
      .sys_clk(sys_clk),
      .rst(rst),
      .sel(utt_clk_sel_t'(cfg_reg[g][CFG_CLK_HI:CFG_CLK_LO])),
      .tick(pre_tick[g])
    );
  end

  always_comb begin
    for (int t = 0; t < TIMERS; t++) begin
      wr_ctl[t] = sfr_req.wr & page_ok & (sfr_req.addr == TMR_BASE[t] + OFF_CTL);
      wr_cfg[t] = sfr_req.wr & page_ok & (sfr_req.addr == TMR_BASE[t] + OFF_CFG);
      wr_capl[t] = sfr_req.wr & page_ok & (sfr_req.addr == TMR_BASE[t] + OFF_CAPL);
      wr_caph[t] = sfr_req.wr & page_ok & (sfr_req.addr == TMR_BASE[t] + OFF_CAPH);
      wr_cntl[t] = sfr_req.wr & page_ok & (sfr_req.addr == TMR_BASE[t] + OFF_CNTL);
      wr_cnth[t] = sfr_req.wr & page_ok & (sfr_req.addr == TMR_BASE[t] + OFF_CNTH);
      wr_bit[t] = (t == BIT_TMR) & bit_req.wr & bit_page_ok &
                  (bit_req.addr[7:3] == TMR_BASE[t][7:3]); // R17
    end
  end

  // Counting, events and register writes for every timer.
  always_comb begin
    for (int t = 0; t < TIMERS; t++) begin
      ctl_next[t] = ctl_reg[t];
      cfg_next[t] = cfg_reg[t];
      cap_next[t] = cap_reg[t];
      cnt_next[t] = cnt_reg[t];
      wrap[t] = 1'b0;
      // Count edges come from the pin or from the prescaler, only while running.
      tick[t] = ctl_reg[t][CTL_RUN] & // R18
                (ctl_reg[t][CTL_CT] ? ex_fall[t] : pre_tick[t]); // R20
      // Capture mode counts down whenever direction enable is set.
      down[t] = cfg_reg[t][CFG_DCEN] & (ctl_reg[t][CTL_CPRL] | // R19
                (ctl_reg[t][CTL_EXT_EDGE_ENABLE] & ~ex_level[t])); // R16 R13
      ext_trig[t] = ctl_reg[t][CTL_EXT_EDGE_ENABLE] & ex_fall[t] & // R13
                    (ctl_reg[t][CTL_CPRL] | ~cfg_reg[t][CFG_DCEN]); // R16
      if (tick[t]) begin
        if (down[t]) begin
          if (ctl_reg[t][CTL_CPRL] ? (cnt_reg[t] == CNT_MIN) : (cnt_reg[t] == cap_reg[t])) begin
            cnt_next[t] = CNT_MAX; // R2
            wrap[t] = 1'b1; // R9
          end else begin
            cnt_next[t] = cnt_reg[t] - 16'h0001;
          end
        end else if (cnt_reg[t] == CNT_MAX) begin
          cnt_next[t] = ctl_reg[t][CTL_CPRL] ? CNT_MIN : cap_reg[t]; // R3
          wrap[t] = 1'b1; // R9
        end else begin
          cnt_next[t] = cnt_reg[t] + 16'h0001;
        end
      end
      if (ext_trig[t]) begin
        if (ctl_reg[t][CTL_CPRL]) begin
          cap_next[t] = cnt_reg[t]; // R14
        end else begin
          cnt_next[t] = cap_reg[t]; // R15
        end
      end
      cfg_next[t][CFG_TOG] = cfg_reg[t][CFG_TOG] ^ wrap[t]; // R1 R7
      // Flags: a hardware set in the cycle of a software clear still sets.
      if (wr_ctl[t]) begin
        ctl_next[t] = sfr_req.wdata;
      end else if (wr_bit[t]) begin
        ctl_next[t][bit_req.addr[2:0]] = bit_req.val;
      end
      ctl_next[t][CTL_WRAP] = ctl_next[t][CTL_WRAP] | wrap[t]; // R9 R10
      ctl_next[t][CTL_EXT] = ctl_next[t][CTL_EXT] | ext_trig[t]; // R11
      if (wr_cfg[t]) begin
        cfg_next[t] = sfr_req.wdata; // R8 R21
      end
      if (wr_capl[t]) begin
        cap_next[t][7:0] = sfr_req.wdata;
      end
      if (wr_caph[t]) begin
        cap_next[t][15:8] = sfr_req.wdata;
      end
      if (wr_cntl[t]) begin
        cnt_next[t][7:0] = sfr_req.wdata;
      end
      if (wr_cnth[t]) begin
        cnt_next[t][15:8] = sfr_req.wdata;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int t = 0; t < TIMERS; t++) begin
      if (rst) begin
        ctl_reg[t] <= CTL_RESET; // R17
        cfg_reg[t] <= CFG_RESET;
        cap_reg[t] <= CNT_RESET;
        cnt_reg[t] <= CNT_RESET;
      end else begin
        ctl_reg[t] <= ctl_next[t];
        cfg_reg[t] <= cfg_next[t];
        cap_reg[t] <= cap_next[t];
        cnt_reg[t] <= cnt_next[t];
      end
    end
  end

  // Read data is registered; an unmapped address or page reads zero.
  always_comb begin
    rdata_next = RDATA_NONE;
    if (sfr_req.rd & page_ok) begin
      for (int t = 0; t < TIMERS; t++) begin
        if (sfr_req.addr == TMR_BASE[t] + OFF_CTL) rdata_next = ctl_reg[t];
        if (sfr_req.addr == TMR_BASE[t] + OFF_CFG) rdata_next = cfg_reg[t]; // R8
        if (sfr_req.addr == TMR_BASE[t] + OFF_CAPL) rdata_next = cap_reg[t][7:0];
        if (sfr_req.addr == TMR_BASE[t] + OFF_CAPH) rdata_next = cap_reg[t][15:8];
        if (sfr_req.addr == TMR_BASE[t] + OFF_CNTL) rdata_next = cnt_reg[t][7:0];
        if (sfr_req.addr == TMR_BASE[t] + OFF_CNTH) rdata_next = cnt_reg[t][15:8];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_reg <= RDATA_NONE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign sfr_rdata = rdata_reg;
  assign toggle_out_pin_a = cfg_reg[0][CFG_TOE] & cfg_reg[0][CFG_TOG]; // R5
  assign toggle_out_oe_a = cfg_reg[0][CFG_TOE]; // R5
  assign toggle_out_pin_b = cfg_reg[1][CFG_TOE] & cfg_reg[1][CFG_TOG]; // R5
  assign toggle_out_oe_b = cfg_reg[1][CFG_TOE]; // R5
  assign wrap_irq_a = ctl_reg[0][CTL_WRAP]; // R10
  assign wrap_irq_b = ctl_reg[1][CTL_WRAP]; // R10

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_TOG_ON_WRAP: assert property ( // R1
    wrap[0] && !wr_cfg[0] |=> cfg_reg[0][CFG_TOG] != $past(cfg_reg[0][CFG_TOG]))
    else $error("toggle state did not invert on wrap");
  AST_DOWN_RELOAD: assert property ( // R2
    tick[0] && down[0] && !ctl_reg[0][CTL_CPRL] && cnt_reg[0] == cap_reg[0] &&
    !ext_trig[0] && !wr_cntl[0] && !wr_cnth[0] |=> cnt_reg[0] == CNT_MAX && ctl_reg[0][CTL_WRAP])
    else $error("down count did not reload 0xffff on match");
  AST_UP_RELOAD: assert property ( // R3
    tick[0] && !down[0] && !ctl_reg[0][CTL_CPRL] && cnt_reg[0] == CNT_MAX &&
    !ext_trig[0] && !wr_cntl[0] && !wr_cnth[0] && !wr_capl[0] && !wr_caph[0]
    |=> cnt_reg[0] == $past(cap_reg[0]))
    else $error("up count did not load capture pair on overflow");
  AST_PIN_GATED: assert property ( // R5
    !cfg_reg[0][CFG_TOE] |-> !toggle_out_pin_a && !toggle_out_oe_a)
    else $error("pin driven while output disabled");
  AST_STOPPED: assert property ( // R7
    !ctl_reg[0][CTL_RUN] && !wr_cfg[0] ##0 !wr_cntl[0] && !wr_cnth[0] && !ext_trig[0]
    |=> $stable(cnt_reg[0]) && $stable(cfg_reg[0][CFG_TOG]))
    else $error("stopped timer moved or toggled");
  AST_WRAP_STICKY: assert property ( // R10
    ctl_reg[0][CTL_WRAP] && !wr_ctl[0] |=> ctl_reg[0][CTL_WRAP])
    else $error("wrap flag cleared without software");
  AST_EXT_IGNORED: assert property ( // R13
    !ctl_reg[0][CTL_EXT_EDGE_ENABLE] && !wr_ctl[0] && !wr_capl[0] && !wr_caph[0]
    |=> $stable(cap_reg[0]) && ctl_reg[0][CTL_EXT] == $past(ctl_reg[0][CTL_EXT]))
    else $error("ext input acted while disabled");
  AST_CAPTURE: assert property ( // R14
    ext_trig[0] && ctl_reg[0][CTL_CPRL] && !wr_capl[0] && !wr_caph[0]
    |=> cap_reg[0] == $past(cnt_reg[0]) && ctl_reg[0][CTL_EXT])
    else $error("capture missed counter value");
  AST_FORCE_TOG: assert property ( // R21
    wr_cfg[1] |=> cfg_reg[1][CFG_TOG] == $past(sfr_req.wdata[CFG_TOG]))
    else $error("forced toggle level not applied");
  AST_RESET_ZERO: assert property ( // R17
    $past(rst) |-> ctl_reg[0] == CTL_RESET && ctl_reg[1] == CTL_RESET)
    else $error("control register not zero after reset");
  AST_RDATA_CFG: assert property ( // R8
    sfr_req.rd && page_ok && sfr_req.addr == TMR_BASE[0] + OFF_CFG
    |=> sfr_rdata == $past(cfg_reg[0]))
    else $error("config read did not return toggle state");

  // Timer b carries the external input checks, since the bench drives only that input.
  AST_TOG_ON_WRAP_B: assert property ( // R1
    wrap[1] && !wr_cfg[1]
    |=> cfg_reg[1][CFG_TOG] != $past(cfg_reg[1][CFG_TOG]))
    else $error("timer b toggle state did not invert on wrap");
  AST_DOWN_RELOAD_B: assert property ( // R2
    tick[1] && !ctl_reg[1][CTL_CPRL] && cfg_reg[1][CFG_DCEN] && ctl_reg[1][CTL_EXT_EDGE_ENABLE] &&
    !ex_level[1] && cnt_reg[1] == cap_reg[1] && !wr_cntl[1] && !wr_cnth[1]
    |=> cnt_reg[1] == CNT_MAX && ctl_reg[1][CTL_WRAP])
    else $error("timer b down count did not reload 0xffff on match");
  AST_DOWN_COUNT_B: assert property ( // R16
    tick[1] && !ctl_reg[1][CTL_CPRL] && cfg_reg[1][CFG_DCEN] && ctl_reg[1][CTL_EXT_EDGE_ENABLE] &&
    !ex_level[1] && cnt_reg[1] != cap_reg[1] && !wr_cntl[1] && !wr_cnth[1]
    |=> cnt_reg[1] == $past(cnt_reg[1]) - 16'h0001)
    else $error("timer b did not count down");
  AST_UP_COUNT_B: assert property ( // R16
    tick[1] && !ctl_reg[1][CTL_CPRL] && (!cfg_reg[1][CFG_DCEN] || ex_level[1]) &&
    cnt_reg[1] != CNT_MAX && !ext_trig[1] && !wr_cntl[1] && !wr_cnth[1]
    |=> cnt_reg[1] == $past(cnt_reg[1]) + 16'h0001)
    else $error("timer b did not count up");
  AST_EXT_IGNORED_B: assert property ( // R13
    !ctl_reg[1][CTL_EXT_EDGE_ENABLE] && !wr_ctl[1] && !wr_bit[1] && !wr_capl[1] && !wr_caph[1]
    |=> $stable(cap_reg[1]) && $stable(ctl_reg[1][CTL_EXT]))
    else $error("timer b ext input acted while disabled");
  AST_CAPTURE_B: assert property ( // R14
    ctl_reg[1][CTL_EXT_EDGE_ENABLE] && ex_fall[1] && ctl_reg[1][CTL_CPRL] && !wr_capl[1] && !wr_caph[1]
    |=> cap_reg[1] == $past(cnt_reg[1]) && ctl_reg[1][CTL_EXT])
    else $error("timer b capture missed counter value");
  AST_EXT_RELOAD_B: assert property ( // R15
    ctl_reg[1][CTL_EXT_EDGE_ENABLE] && ex_fall[1] && !ctl_reg[1][CTL_CPRL] && !cfg_reg[1][CFG_DCEN] &&
    !wr_cntl[1] && !wr_cnth[1]
    |=> cnt_reg[1] == $past(cap_reg[1]) && ctl_reg[1][CTL_EXT])
    else $error("timer b edge did not reload counter");
  AST_STOPPED_B: assert property ( // R18
    !ctl_reg[1][CTL_RUN] && !wr_cfg[1] && !wr_cntl[1] && !wr_cnth[1] && !ext_trig[1]
    |=> $stable(cnt_reg[1]) && $stable(cfg_reg[1][CFG_TOG]))
    else $error("timer b moved or toggled while stopped");
  AST_COUNT_SOURCE_B: assert property ( // R20
    ctl_reg[1][CTL_RUN] && ctl_reg[1][CTL_CT] && !ex_fall[1] && !wr_cntl[1] && !wr_cnth[1]
    |=> $stable(cnt_reg[1]))
    else $error("timer b counted without an input edge");
  AST_WRAP_STICKY_B: assert property ( // R10
    ctl_reg[1][CTL_WRAP] && !wr_ctl[1] && !wr_bit[1]
    |=> ctl_reg[1][CTL_WRAP])
    else $error("timer b wrap flag cleared without software");
  AST_EXT_STICKY_B: assert property ( // R11
    ctl_reg[1][CTL_EXT] && !wr_ctl[1] && !wr_bit[1]
    |=> ctl_reg[1][CTL_EXT])
    else $error("timer b ext flag cleared without software");
  AST_BIT_WRITE_B: assert property ( // R17
    wr_bit[1] && !wr_ctl[1] && !wrap[1] && !ext_trig[1]
    |=> ctl_reg[1][$past(bit_req.addr[2:0])] == $past(bit_req.val))
    else $error("single-bit write did not land");
  AST_PIN_GATED_B: assert property ( // R5
    !cfg_reg[1][CFG_TOE]
    |-> !toggle_out_pin_b && !toggle_out_oe_b)
    else $error("timer b pin driven while output disabled");

  COV_WRAP_UP: cover property (wrap[0] && !down[0]);
  COV_WRAP_DOWN: cover property (wrap[1] && down[1]);
  COV_CAPTURE: cover property (ext_trig[1] && ctl_reg[1][CTL_CPRL]);
  COV_EXT_RELOAD: cover property (ext_trig[1] && !ctl_reg[1][CTL_CPRL]);
  COV_BIT_WRITE: cover property (wr_bit[1]);

endmodule // utt_top

//--- verification/utt_pin_model.sv
module utt_pin_model
  import utt_pkg::*;
(
  input wire logic sys_clk, // System clock.
  input wire logic level_req, // Idle level asked for by the bench.
  input wire logic strike, // One-cycle request for a falling edge.
  input wire logic pin, // Toggle level from the design.
  input wire logic oe, // Output enable from the design.
  output logic ext, // External control input level.
  output logic pin_seen // Pin level as the board sees it.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] low_reg = 3'h0;
  logic [2:0] low_next;
  always_comb begin
    low_next = strike ? 3'h4 : ((low_reg != 3'h0) ? low_reg - 3'h1 : 3'h0);
  end
  always_ff @(posedge sys_clk) begin
    low_reg <= low_next;
  end
  // The low phase lasts four cycles so that the two-flop synchroniser cannot miss it.
  assign ext = (low_reg != 3'h0) ? 1'b0 : level_req;
  // An undriven pin settles low through its pull-down.
  assign pin_seen = oe ? pin : 1'b0;
endmodule // utt_pin_model

//--- verification/tb_top.sv
module tb_top;
  import utt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  utt_sfr_req_t sfr_req = '0;
  utt_bit_req_t bit_req = '0;
  logic [7:0] sfr_rdata;
  logic [1:0] lvl = 2'h3;
  logic [1:0] stk = 2'h0;
  logic [1:0] ext;
  logic [1:0] seen;
  logic pin_a, pin_b, oe_a, oe_b, irq_a, irq_b;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  integer seed = 32'hf3b5;
  logic [7:0] exp_q[$];
  string nm_q[$];
  logic rd_d = 1'b0;
  logic [15:0] v;
  int n;
  logic p;

  utt_top i_utt_top (.sys_clk(sys_clk), .rst(rst), .sfr_req(sfr_req), .bit_req(bit_req),
    .sfr_rdata(sfr_rdata), .ext_control_input_a(ext[0]), .ext_control_input_b(ext[1]),
    .toggle_out_pin_a(pin_a), .toggle_out_oe_a(oe_a), .toggle_out_pin_b(pin_b),
    .toggle_out_oe_b(oe_b), .wrap_irq_a(irq_a), .wrap_irq_b(irq_b));
  utt_pin_model i_utt_pin_model [1:0] (.sys_clk(sys_clk), .level_req(lvl), .strike(stk),
    .pin({pin_b, pin_a}), .oe({oe_b, oe_a}), .ext(ext), .pin_seen(seen));

  always #20 sys_clk = ~sys_clk;

  task automatic check(string nm, logic [7:0] seen_v, logic [7:0] exp_v);
    n_tests++;
    if (seen_v !== exp_v) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp_v, seen_v);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Requests change only at falling edges; a read notes its expected byte in the queue.
  task automatic acc(logic w, logic [7:0] pg, logic [7:0] a, logic [7:0] d, string nm);
    sfr_req <= '{wr: w, rd: !w, page: pg, addr: a, wdata: w ? d : 8'h00};
    if (!w) begin
      exp_q.push_back(d);
      nm_q.push_back(nm);
    end
    @(negedge sys_clk);
  endtask

  task automatic wr(int t, logic [7:0] off, logic [7:0] d);
    acc(1'b1, SFR_PAGE, TMR_BASE[t] + off, d, "");
  endtask

  task automatic rd(int t, logic [7:0] off, logic [7:0] e, string nm);
    acc(1'b0, SFR_PAGE, TMR_BASE[t] + off, e, nm);
  endtask

  task automatic idle(int k);
    sfr_req <= '0;
    repeat (k + 1) @(negedge sys_clk);
  endtask

  task automatic strike(int t);
    idle(1);
    stk[t] <= 1'b1;
    @(negedge sys_clk);
    stk <= 2'h0;
    repeat (9) @(negedge sys_clk);
  endtask

  always @(posedge sys_clk) rd_d <= sfr_req.rd;

  always @(negedge sys_clk) begin
    if (rd_d === 1'b1) check(nm_q.pop_front(), sfr_rdata, exp_q.pop_front());
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      wrap_up();
    end
  end

  initial begin
    repeat (5) @(negedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    rd(0, OFF_CTL, 8'h00, "ctl_a_reset");
    rd(1, OFF_CTL, 8'h00, "ctl_b_reset");
    rd(0, OFF_CFG, 8'h00, "cfg_a_reset");
    acc(1'b1, 8'h00, TMR_BASE[1], 8'h0c, "");
    rd(1, OFF_CTL, 8'h00, "ctl_b_other_page");
    bit_req <= '{wr: 1'b1, page: SFR_PAGE, addr: TMR_BASE[1] + 8'h03, val: 1'b1};
    idle(0);
    bit_req <= '0;
    rd(1, OFF_CTL, 8'h08, "ctl_b_bit_write");
    // A reload of 0xfffd at the undivided clock gives a half period of three cycles.
    wr(0, OFF_CAPL, 8'hfd);
    wr(0, OFF_CAPH, 8'hff);
    wr(0, OFF_CNTL, 8'hfd);
    wr(0, OFF_CNTH, 8'hff);
    wr(0, OFF_CFG, 8'h0a);
    wr(0, OFF_CTL, 8'h00);
    idle(10);
    check("oe_a", {7'h00, oe_a}, 8'h01);
    check("pin_a_before_run", {7'h00, seen[0]}, 8'h00);
    wr(0, OFF_CTL, 8'h04);
    idle(0);
    for (int i = 0; i < 5; i++) begin
      n = 0;
      p = seen[0];
      while (seen[0] === p && n < 20) begin
        @(negedge sys_clk);
        n++;
      end
      if (i > 0) check("half_period", n[7:0], 8'h03);
    end
    rd(0, OFF_CTL, 8'h84, "ctl_a_wrap");
    wr(0, OFF_CTL, 8'h80);
    idle(5);
    check("irq_a_held", {7'h00, irq_a}, 8'h01);
    wr(0, OFF_CTL, 8'h00);
    idle(0);
    check("irq_a_cleared", {7'h00, irq_a}, 8'h00);
    wr(0, OFF_CNTL, 8'h34);
    wr(0, OFF_CNTH, 8'h12);
    idle(8);
    rd(0, OFF_CNTL, 8'h34, "cnt_a_stopped");
    wr(0, OFF_CFG, 8'h0e);
    idle(0);
    check("pin_a_forced_high", {7'h00, seen[0]}, 8'h01);
    rd(0, OFF_CFG, 8'h0e, "cfg_a_toggle");
    wr(0, OFF_CFG, 8'h0a);
    idle(0);
    check("pin_a_forced_low", {7'h00, seen[0]}, 8'h00);
    wr(0, OFF_CFG, 8'h0c);
    idle(0);
    check("oe_a_off", {6'h00, oe_a, seen[0]}, 8'h00);
    // Capture on timer b: first with the edge input disabled, then enabled.
    v = 16'($random(seed));
    wr(1, OFF_CTL, 8'h00);
    wr(1, OFF_CNTL, v[7:0]);
    wr(1, OFF_CNTH, v[15:8]);
    wr(1, OFF_CTL, 8'h01);
    strike(1);
    rd(1, OFF_CAPL, 8'h00, "cap_b_ignored");
    rd(1, OFF_CTL, 8'h01, "ctl_b_ignored");
    wr(1, OFF_CTL, 8'h09);
    strike(1);
    rd(1, OFF_CAPL, v[7:0], "capl_b");
    rd(1, OFF_CAPH, v[15:8], "caph_b");
    rd(1, OFF_CTL, 8'h49, "ctl_b_capture");
    v = 16'($random(seed));
    wr(1, OFF_CAPL, v[7:0]);
    wr(1, OFF_CAPH, v[15:8]);
    wr(1, OFF_CTL, 8'h08);
    strike(1);
    rd(1, OFF_CNTL, v[7:0], "cntl_b_reload");
    rd(1, OFF_CNTH, v[15:8], "cnth_b_reload");
    rd(1, OFF_CTL, 8'h48, "ctl_b_reload");
    wr(1, OFF_CTL, 8'h02);
    wr(1, OFF_CNTL, 8'h00);
    wr(1, OFF_CNTH, 8'h00);
    wr(1, OFF_CTL, 8'h06);
    for (int i = 0; i < 3; i++) strike(1);
    wr(1, OFF_CTL, 8'h00);
    rd(1, OFF_CNTL, 8'h03, "cnt_b_edges");
    // Down count from 5 to a reload value of 0 wraps within a few ticks; up does not.
    wr(1, OFF_CFG, 8'h09);
    wr(1, OFF_CAPL, 8'h00);
    wr(1, OFF_CAPH, 8'h00);
    for (int dir = 0; dir < 2; dir++) begin
      wr(1, OFF_CTL, 8'h08);
      wr(1, OFF_CNTL, 8'h05);
      wr(1, OFF_CNTH, 8'h00);
      lvl[1] <= dir[0];
      idle(5);
      wr(1, OFF_CTL, 8'h0c);
      idle(12);
      // Stop through a single-bit write so that the wrap flag survives.
      bit_req <= '{wr: 1'b1, page: SFR_PAGE, addr: TMR_BASE[1] + 8'h02, val: 1'b0};
      idle(0);
      bit_req <= '0;
      rd(1, OFF_CTL, dir == 0 ? 8'h88 : 8'h08, "ctl_b_direction");
      rd(1, OFF_CNTH, dir == 0 ? 8'hff : 8'h00, "cnth_b_direction");
      check("irq_b", {7'h00, irq_b}, dir == 0 ? 8'h01 : 8'h00);
    end
    wr(1, OFF_CFG, 8'h06);
    idle(0);
    check("pin_b_forced_high", {6'h00, oe_b, seen[1]}, 8'h03);
    // A reset in mid-run must clear a running timer as well.
    wr(0, OFF_CTL, 8'h04);
    idle(2);
    rst <= 1'b1;
    repeat (2) @(negedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    rd(0, OFF_CTL, 8'h00, "ctl_a_mid_reset");
    rd(0, OFF_CNTH, 8'h00, "cnth_a_mid_reset");
    idle(3);
    wrap_up();
  end
endmodule // tb_top
